/* core/adc_serial_port_reset_control.sv */
// Purpose: Reset, power state, data-ready timing and serial port of a converter
// Assumes: REF_CLK_I is the master clock; SCLK_I is the host's link clock
// Notes:   Master and link logic meet through toggle synchronisers, the port reset and the configuration read
// Function
// - Reset pin must stay low two master clocks to be honoured.
// - Device stays in reset while reset pin low; resumes after release.
// - Reset command acts on third master edge after command's eighth rising serial edge.
// - Any reset restores configuration defaults and resynchronises conversion.
// - FIR first data after restart: 62.98046875 data periods plus 468 clocks.
// - Wake command latency is two master clocks shorter.
// - Power-on and power-down release default to 1000 per second, FIR.
// - Supplies ANDed, then 2^16 clocks counted before internal reset release.
// - Power-down pin low disables logic and restores register defaults.
// - Outputs stay driven in power-down; host keeps inputs defined.
// - Standby keeps serial port and configuration working and intact.
// - Rising chip select cancels standby and stopped continuous read.
// - Chip select high tristates output, ignores clock, aborts transfer.
// - Input sampled on rising serial edge, output changes on falling.
// - Serial clock low for 64 ready cycles resets the serial port.
// - After timeout reset the next serial pulse starts a new byte.
// - Output data rates scale with master clock frequency.
// - Ready output falls on new data; it paces the timeout count.
// - Sinc latency follows per-rate clock count table.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_consts.svh"

module adc_serial_port_reset_control #(
  parameter int POR_CYCLES     = 65536,
  parameter int DATA_PERIOD_1K = 4096
) (
  input  wire logic       REF_CLK_I,
  input  wire logic       RST_I,
  input  wire logic       RESET_N_I,
  input  wire logic       POWER_DOWN_N_I,
  input  wire logic [1:0] SUPPLY_GOOD_I,
  input  wire logic       SCLK_I,
  input  wire logic       CS_N_I,
  input  wire logic       DIN_I,
  output logic            DOUT_O,
  output logic            DOUT_OE_N_O,
  output logic            RESULT_READY_N_O,
  output logic            INT_RESET_O,
  output logic            POWERED_DOWN_O,
  output logic            STANDBY_O,
  output logic            CONT_READ_O,
  output logic            FIR_MODE_O,
  output logic [2:0]      DATA_RATE_O,
  output logic            CONV_SYNC_O
);

  // ----------------------------------------------------------------
  // Rate tables
  // ----------------------------------------------------------------
  localparam logic [23:0] FIR_BASE_PER = 24'(DATA_PERIOD_1K * 4);
  localparam logic [16:0] POR_LAST     = 17'(POR_CYCLES - 1);

  function automatic logic [23:0] period_f(input adc_port_pkg::cfg_t c);
    logic [23:0] p;
    p = c.fir ? (FIR_BASE_PER >> c.rate) : (`SINC_PER_128K << c.rate);
    return p;
  endfunction

  function automatic logic [23:0] lat_f(input adc_port_pkg::cfg_t c);
    logic [39:0] m;
    logic [23:0] l;
    m = {16'h0000, period_f(c)} * {24'h000000, `FIR_FRAC_NUM};
    l = `SINC_LAT_8K;
    if (c.fir)
    begin
      l = m[31:8] + `FIR_LAT_CLK;
    end
    else
    begin
      case (c.rate)
        3'h0:    l = `SINC_LAT_128K;
        3'h1:    l = `SINC_LAT_64K;
        3'h2:    l = `SINC_LAT_32K;
        3'h3:    l = `SINC_LAT_16K;
        default: l = `SINC_LAT_8K;
      endcase
    end
    return l;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  adc_port_pkg::master_t    m_q;
  adc_port_pkg::master_t    m_d;
  adc_port_pkg::rise_t      r_q;
  adc_port_pkg::rise_t      r_d;
  adc_port_pkg::fall_t      f_q;
  adc_port_pkg::fall_t      f_d;
  adc_port_pkg::async_t     a_in;
  adc_port_pkg::cfg_t       cfg_def;
  logic                     link_arst;
  logic                     cs_rise_w;
  logic                     act_w;
  logic                     byte_new_w;
  logic                     pin_rst_w;
  logic                     cmd_rst_w;
  logic                     hold_w;
  logic [7:0]               cfg_byte;

  assign cfg_def   = adc_port_pkg::cfg_t'({`CFG_FIR_DEF, `CFG_RATE_DEF});
  assign a_in      = adc_port_pkg::async_t'({RESET_N_I, POWER_DOWN_N_I, SUPPLY_GOOD_I,
                                             CS_N_I, r_q.act_tog, r_q.byte_tog});
  // Port reset is a master flop, so no glitch reaches the link flops
  assign link_arst = CS_N_I | m_q.link_rst;

  // ----------------------------------------------------------------
  // Master clock events
  // ----------------------------------------------------------------
  assign cs_rise_w  = m_q.s2.cs_n & ~m_q.cs_q;
  assign act_w      = m_q.s2.act_tog ^ m_q.act_q;
  // Toggles drop to zero at port reset; quiet window hides that step
  assign byte_new_w = (m_q.s2.byte_tog ^ m_q.byte_q) & ~m_q.s2.cs_n
                      & ~m_q.link_rst & (m_q.quiet == 2'h0);
  assign pin_rst_w  = ~m_q.s2.rst_n & (m_q.pin_cnt >= (`RST_PIN_MIN - 2'h1));
  assign cmd_rst_w  = byte_new_w & ~r_q.out.data & (r_q.out.val == `CMD_RESET);
  assign hold_w     = ~m_q.por_done | pin_rst_w | ~m_q.s2.power_down_n | cmd_rst_w;

  always_comb
  begin
    logic restart;
    logic wake;
    logic data_evt;
    restart  = 1'b0;
    wake     = 1'b0;
    data_evt = 1'b0;
    m_d      = m_q;
    m_d.s1   = a_in;
    m_d.s2   = m_q.s1;
    m_d.cs_q = m_q.s2.cs_n;
    m_d.act_q  = m_q.s2.act_tog;
    m_d.byte_q = m_q.s2.byte_tog;
    m_d.sync_pulse = 1'b0;
    m_d.wake   = 1'b0;
    if (m_q.s2.cs_n | m_q.link_rst)
    begin
      m_d.quiet = `QUIET_CYC;
    end
    else if (m_q.quiet != 2'h0)
    begin
      m_d.quiet = m_q.quiet - 2'h1;
    end
    // Supplies ANDed before the long count
    if (&m_q.s2.sup)
    begin
      if (!m_q.por_done)
      begin
        if (m_q.por_cnt == POR_LAST)
        begin
          m_d.por_done = 1'b1;
        end
        else
        begin
          m_d.por_cnt = m_q.por_cnt + 17'h00001;
        end
      end
    end
    else
    begin
      m_d.por_cnt  = 17'h00000;
      m_d.por_done = 1'b0;
    end
    if (!m_q.s2.rst_n)
    begin
      if (m_q.pin_cnt != `RST_PIN_MIN)
      begin
        m_d.pin_cnt = m_q.pin_cnt + 2'h1;
      end
    end
    else
    begin
      m_d.pin_cnt = 2'h0;
    end
    m_d.int_reset    = hold_w;
    m_d.powered_down = ~m_q.s2.power_down_n;
    if (hold_w)
    begin
      // Defaults reload every held cycle; counting starts at release
      m_d.cfg        = cfg_def;
      m_d.standby    = 1'b0;
      m_d.cont_read  = 1'b1;
      m_d.wait_first = 1'b1;
      m_d.ready_n    = 1'b1;
      m_d.cnt        = lat_f(cfg_def) - 24'h000001;
      m_d.sync_pulse = 1'b1;
    end
    else
    begin
      if (byte_new_w)
      begin
        if (r_q.out.data)
        begin
          m_d.cfg = r_q.out.val[3:0];
          restart = 1'b1;
        end
        else
        begin
          case (r_q.out.val)
            `CMD_WAKE:
            begin
              if (m_q.standby)
              begin
                m_d.standby = 1'b0;
                restart     = 1'b1;
                wake        = 1'b1;
              end
            end
            `CMD_STANDBY: m_d.standby   = 1'b1;
            `CMD_SYNC:    restart       = 1'b1;
            `CMD_READ_CONT: m_d.cont_read = 1'b1;
            `CMD_STOP_CONT: m_d.cont_read = 1'b0;
            default:      m_d.cont_read = m_q.cont_read;
          endcase
        end
      end
      if (cs_rise_w)
      begin
        m_d.standby   = 1'b0;
        m_d.cont_read = 1'b1;
        restart       = restart | m_q.standby;
      end
      if (m_d.standby)
      begin
        m_d.ready_n = 1'b1;
      end
      else if (restart)
      begin
        m_d.cnt        = lat_f(m_d.cfg) - 24'h000001 - (wake ? `WAKE_TRIM : 24'h000000);
        m_d.wait_first = 1'b1;
        m_d.ready_n    = 1'b1;
        m_d.sync_pulse = 1'b1;
        m_d.wake       = wake;
      end
      else if (m_q.cnt == 24'h000000)
      begin
        m_d.ready_n    = 1'b0;
        m_d.wait_first = 1'b0;
        m_d.cnt        = period_f(m_q.cfg) - 24'h000001;
        data_evt       = 1'b1;
      end
      else
      begin
        m_d.cnt = m_q.cnt - 24'h000001;
        if (!m_q.wait_first && (m_q.cnt == `READY_HIGH))
        begin
          m_d.ready_n = 1'b1;
        end
      end
    end
    // Idle serial clock counted in ready pulses
    if (act_w || cs_rise_w || hold_w)
    begin
      m_d.tmo = 7'h00;
    end
    else if (data_evt)
    begin
      if (m_q.tmo == (`TMO_PULSES - 7'h01))
      begin
        m_d.tmo      = 7'h00;
        m_d.link_cnt = `LINK_RST_CYC;
      end
      else
      begin
        m_d.tmo = m_q.tmo + 7'h01;
      end
    end
    if ((m_q.link_cnt != 3'h0) && (m_d.link_cnt == m_q.link_cnt))
    begin
      m_d.link_cnt = m_q.link_cnt - 3'h1;
    end
    m_d.link_rst = (m_d.link_cnt != 3'h0);
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      m_q            <= '0;
      // Synchronisers start at pin idle levels, so no false edge follows
      m_q.s1         <= '{rst_n: 1'b1, power_down_n: 1'b1, sup: 2'h0, cs_n: 1'b1,
                          act_tog: 1'b0, byte_tog: 1'b0};
      m_q.s2         <= '{rst_n: 1'b1, power_down_n: 1'b1, sup: 2'h0, cs_n: 1'b1,
                          act_tog: 1'b0, byte_tog: 1'b0};
      m_q.cs_q       <= 1'b1;
      m_q.cfg        <= adc_port_pkg::cfg_t'({`CFG_FIR_DEF, `CFG_RATE_DEF});
      m_q.cont_read  <= 1'b1;
      m_q.wait_first <= 1'b1;
      m_q.ready_n    <= 1'b1;
      m_q.int_reset  <= 1'b1;
      m_q.quiet      <= `QUIET_CYC;
      m_q.link_cnt   <= `LINK_RST_CYC;
      m_q.link_rst   <= 1'b1;
    end
    else
    begin
      m_q <= m_d;
    end
  end

  // ----------------------------------------------------------------
  // Link side: shift in on rising edge
  // ----------------------------------------------------------------
  always_comb
  begin
    r_d         = r_q;
    r_d.sh      = {r_q.sh[6:0], DIN_I};
    r_d.bits    = r_q.bits + 3'h1;
    r_d.act_tog = ~r_q.act_tog;
    if (r_q.bits == `BYTE_LAST)
    begin
      r_d.out.val   = {r_q.sh[6:0], DIN_I};
      r_d.out.data  = r_q.data_next;
      r_d.byte_tog  = ~r_q.byte_tog;
      r_d.data_next = ~r_q.data_next & ({r_q.sh[6:0], DIN_I} == `CMD_WR_CFG);
      r_d.rd_arm    = ~r_q.data_next & ({r_q.sh[6:0], DIN_I} == `CMD_RD_CFG);
    end
  end

  // Port reset clears the bit count, so the next pulse is bit one
  always_ff @(posedge SCLK_I or posedge link_arst)
  begin
    if (link_arst)
    begin
      r_q <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Link side: shift out on falling edge
  // ----------------------------------------------------------------
  // Configuration changes only by this port or a reset, so it is steady while read
  assign cfg_byte = {4'h0, m_q.cfg};

  always_comb
  begin
    f_d      = f_q;
    f_d.oe_n = 1'b0;
    f_d.dout = r_q.rd_arm ? cfg_byte[~r_q.bits] : 1'b0;
  end

  always_ff @(negedge SCLK_I or posedge link_arst)
  begin
    if (link_arst)
    begin
      f_q <= '{dout: 1'b0, oe_n: 1'b1};
    end
    else
    begin
      f_q <= f_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all driven in power-down too
  // ----------------------------------------------------------------
  assign DOUT_O           = f_q.dout;
  assign DOUT_OE_N_O      = f_q.oe_n;
  assign RESULT_READY_N_O = m_q.ready_n;
  assign INT_RESET_O      = m_q.int_reset;
  assign POWERED_DOWN_O   = m_q.powered_down;
  assign STANDBY_O        = m_q.standby;
  assign CONT_READ_O      = m_q.cont_read;
  assign FIR_MODE_O       = m_q.cfg.fir;
  assign DATA_RATE_O      = m_q.cfg.rate;
  assign CONV_SYNC_O      = m_q.sync_pulse;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_PIN_HOLD: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (!m_q.s2.rst_n && $past(!m_q.s2.rst_n)) |=> INT_RESET_O)
    else $error("reset pin low without internal reset");
  AST_CMD_RESET: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    cmd_rst_w |=> (INT_RESET_O && CONV_SYNC_O && FIR_MODE_O && (DATA_RATE_O == `CFG_RATE_DEF)))
    else $error("reset command not applied");
  AST_DEFAULTS: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (!m_q.s2.power_down_n) |=> (POWERED_DOWN_O && CONT_READ_O && !STANDBY_O
                          && (m_q.cfg == cfg_def) && RESULT_READY_N_O))
    else $error("power-down did not restore defaults");
  AST_POR: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $rose(m_q.por_done) |-> ($past(m_q.por_cnt) == POR_LAST) && $past(&m_q.s2.sup))
    else $error("power-on count wrong");
  AST_FIR_LAT: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (CONV_SYNC_O && !m_q.wake && !hold_w && !m_q.standby)
      |-> (m_q.cnt == lat_f(m_q.cfg) - 24'h000001))
    else $error("first data latency wrong");
  AST_WAKE_LAT: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    m_q.wake |-> (m_q.cnt == lat_f(m_q.cfg) - `WAKE_TRIM - 24'h000001) && CONV_SYNC_O)
    else $error("wake latency wrong");
  AST_CS_CANCEL: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    cs_rise_w |=> (!STANDBY_O && CONT_READ_O))
    else $error("chip select rise did not cancel modes");
  AST_TIMEOUT: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $rose(m_q.link_rst) |-> ($past(m_q.tmo) == (`TMO_PULSES - 7'h01)) ##1 m_q.link_rst [*3])
    else $error("port timeout fired at wrong count");
  AST_OE: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    m_q.s2.cs_n |-> DOUT_OE_N_O)
    else $error("output driven while deselected");
  AST_READY: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $fell(RESULT_READY_N_O) |-> ($past(m_q.cnt) == 24'h000000) && !STANDBY_O)
    else $error("ready fell off schedule");
  AST_STANDBY_KEEP: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (STANDBY_O && !byte_new_w && !hold_w) |=> ($stable(m_q.cfg) && STANDBY_O == !$past(cs_rise_w)))
    else $error("standby disturbed configuration");

endmodule
`default_nettype wire

/* core/adc_port_consts.svh */
// Purpose: Constants for the converter serial port and reset block
// Assumes: Master clock counts; command codes are local choices
// Notes:   Included by bare name
`ifndef ADC_PORT_CONSTS_SVH
`define ADC_PORT_CONSTS_SVH

// ----------------------------------------------------------------
// Serial commands
// ----------------------------------------------------------------
`define CMD_WAKE     8'h02
`define CMD_STANDBY  8'h04
`define CMD_RESET    8'h06
`define CMD_SYNC     8'h08
`define CMD_READ_CONT 8'h10
`define CMD_STOP_CONT 8'h11
`define CMD_RD_CFG   8'h20
`define CMD_WR_CFG   8'h40

// ----------------------------------------------------------------
// Defaults and timing counts
// ----------------------------------------------------------------
`define CFG_FIR_DEF   1'h1
`define CFG_RATE_DEF  3'h2
`define BYTE_LAST     3'h7
`define RST_PIN_MIN   2'h2
`define FIR_FRAC_NUM  16'h3efb
`define FIR_LAT_CLK   24'h0001d4
`define WAKE_TRIM     24'h000002
`define READY_HIGH    24'h000004
`define SINC_PER_128K 24'h000020
`define SINC_LAT_128K 24'h0001b8
`define SINC_LAT_64K  24'h000268
`define SINC_LAT_32K  24'h0003c8
`define SINC_LAT_16K  24'h000688
`define SINC_LAT_8K   24'h000b08
`define TMO_PULSES    7'h40
`define LINK_RST_CYC  3'h4
`define QUIET_CYC     2'h3

`endif

/* core/adc_port_pkg.sv */
// Purpose: Types for the converter serial port and reset block
// Assumes: Fixed counter widths cover the slowest data rate
// Notes:   Constants live in adc_port_consts.svh
package adc_port_pkg;

  typedef struct packed {
    logic       rst_n;
    logic       power_down_n;
    logic [1:0] sup;
    logic       cs_n;
    logic       act_tog;
    logic       byte_tog;
  } async_t;

  typedef struct packed {
    logic       fir;
    logic [2:0] rate;
  } cfg_t;

  typedef struct packed {
    logic       data;
    logic [7:0] val;
  } link_byte_t;

  typedef struct packed {
    async_t      s1;
    async_t      s2;
    logic        cs_q;
    logic        act_q;
    logic        byte_q;
    logic [1:0]  quiet;
    logic [16:0] por_cnt;
    logic        por_done;
    logic [1:0]  pin_cnt;
    cfg_t        cfg;
    logic        standby;
    logic        cont_read;
    logic        wait_first;
    logic        wake;
    logic [23:0] cnt;
    logic        ready_n;
    logic        sync_pulse;
    logic [6:0]  tmo;
    logic [2:0]  link_cnt;
    logic        link_rst;
    logic        int_reset;
    logic        powered_down;
  } master_t;

  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] bits;
    logic       act_tog;
    logic       byte_tog;
    logic       data_next;
    logic       rd_arm;
    link_byte_t out;
  } rise_t;

  typedef struct packed {
    logic dout;
    logic oe_n;
  } fall_t;

endpackage

/* tb/adc_host_model.sv */
// Purpose: Host side of the converter serial port
// Assumes: Mode 0 framing, link clock period 6 ns
// Notes:   Link clock stands low outside frames
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic dout_i,
  input  wire logic dout_oe_n_i
);
  logic dout_last;
  logic line;

  // ----------------------------------------------------------------
  // Wire level
  // ----------------------------------------------------------------
  // Released line shows inverse of last bit, so a stale value never matches
  assign line = dout_oe_n_i ? ~dout_last : dout_i;
  always @(dout_i or dout_oe_n_i)
    if (!dout_oe_n_i)
      dout_last = dout_i;

  initial
  begin
    sclk_o    = 1'b0;
    cs_n_o    = 1'b1;
    din_o     = 1'b0;
    dout_last = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frames
  // ----------------------------------------------------------------
  // Select change needs three master edges to pass the synchroniser
  task automatic sel(input logic v);
    cs_n_o = v;
    #200;
  endtask

  // Gap of 300 ns after a byte keeps completions more than 300 ns apart
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      din_o = tx[i];
      #3 sclk_o = 1'b1;
      rx[i] = line;
      #3 sclk_o = 1'b0;
    end
    din_o = 1'b0;
    #300;
  endtask
endmodule
`default_nettype wire

/* tb/adc_serial_port_reset_control_test.sv */
// Purpose: Self-checking bench for the serial port and reset block
// Assumes: Short power-on count and data period for run time
// Notes:   Samples on falling master edge, drives on rising
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_consts.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  $display("wrong value %s exp %0h got %0h", nm, e, g); fails++; end end
module adc_serial_port_reset_control_test;
  localparam int POR = 16;
  localparam int DP  = 256;
  localparam int LAT = DP * 16123 / 256 + 468;
  logic       clk, rst, rst_pin_n, power_down_n;
  logic [1:0] sup;
  wire logic  sclk, cs_n, din;
  logic       dout, oe_n, ready_n, int_rst, pdn, stby, cont, fir, conv_sync;
  logic [2:0] rate;
  logic [7:0] rx;
  int         fails, checks_done;

  adc_serial_port_reset_control #(.POR_CYCLES(POR), .DATA_PERIOD_1K(DP))
    adc_serial_port_reset_control_i (
    .REF_CLK_I(clk), .RST_I(rst), .RESET_N_I(rst_pin_n), .POWER_DOWN_N_I(power_down_n),
    .SUPPLY_GOOD_I(sup), .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din), .DOUT_O(dout),
    .DOUT_OE_N_O(oe_n), .RESULT_READY_N_O(ready_n), .INT_RESET_O(int_rst),
    .POWERED_DOWN_O(pdn), .STANDBY_O(stby), .CONT_READ_O(cont), .FIR_MODE_O(fir),
    .DATA_RATE_O(rate), .CONV_SYNC_O(conv_sync));

  adc_host_model adc_host_model_i (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
    .dout_i(dout), .dout_oe_n_i(oe_n));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic cmd(input logic [7:0] b);
    adc_host_model_i.xfer(b, 8, rx);
  endtask

  task automatic settle(output int n);
    n = 0;
    while (int_rst !== 1'b0 && n < 300)
    begin
      cyc(1);
      n++;
    end
  endtask

  task automatic falls(input int n);
    repeat (n)
    begin
      while (ready_n !== 1'b1) cyc(1);
      while (ready_n !== 1'b0) cyc(1);
    end
  endtask

  // Edges from restart pulse to ready fall
  task automatic lat(output int n);
    int k;
    k = 0;
    while (conv_sync !== 1'b1 && k < 200)
    begin
      cyc(1);
      k++;
    end
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end
    while (ready_n !== 1'b0 && n < 20000);
  endtask

  task automatic wr_cfg(input logic [7:0] v);
    cmd(`CMD_WR_CFG);
    cmd(v);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_por;
    int n;
    cyc(1);
    `CHK("int reset", 1'b1, int_rst)
    @(posedge clk) sup <= 2'h1;
    cyc(POR + 10);
    `CHK("one supply", 1'b1, int_rst)
    @(posedge clk) sup <= 2'h3;
    settle(n);
    `CHK("por span", 1'b1, n >= POR && n <= POR + 6)
    `CHK("fir default", 1'b1, fir)
    `CHK("rate default", 3'h2, rate)
  endtask

  task automatic t_fir;
    int n;
    int a;
    int b;
    fork
      lat(n);
      cmd(`CMD_SYNC);
    join
    `CHK("fir latency", LAT, n)
    a = 0;
    b = 0;
    while (ready_n !== 1'b1 && a < 2 * DP)
    begin
      cyc(1);
      a++;
    end
    while (ready_n !== 1'b0 && b < 2 * DP)
    begin
      cyc(1);
      b++;
    end
    `CHK("ready period", DP, a + b)
    `CHK("ready high", 4, b)
  endtask

  task automatic t_wake;
    int n;
    cmd(`CMD_STANDBY);
    `CHK("standby", 1'b1, stby)
    cyc(2 * DP);
    `CHK("idle ready", 1'b1, ready_n)
    fork
      lat(n);
      cmd(`CMD_WAKE);
    join
    `CHK("wake latency", LAT - 2, n)
  endtask

  // Partial byte, then link clock idle past the timeout
  task automatic t_tmo;
    adc_host_model_i.xfer(8'h00, 3, rx);
    `CHK("oe driving", 1'b0, oe_n)
    falls(63);
    `CHK("port alive", 1'b0, oe_n)
    falls(1);
    `CHK("port reset", 1'b1, oe_n)
    // Bits sent while the port reset stands would be dropped
    cyc(8);
    cmd(`CMD_STANDBY);
    `CHK("fresh byte", 1'b1, stby)
    adc_host_model_i.sel(1'b1);
    `CHK("standby cancel", 1'b0, stby)
    adc_host_model_i.sel(1'b0);
  endtask

  task automatic t_cfg;
    int n;
    wr_cfg(8'h03);
    `CHK("fir write", 1'b0, fir)
    `CHK("rate write", 3'h3, rate)
    cmd(`CMD_STANDBY);
    cmd(`CMD_RD_CFG);
    cmd(8'h00);
    `CHK("cfg read", 8'h03, rx)
    cmd(8'h11);
    `CHK("stopped read", 1'b0, cont)
    cmd(`CMD_READ_CONT);
    `CHK("read mode", 1'b1, cont)
    cmd(`CMD_STOP_CONT);
    `CHK("stopped again", 1'b0, cont)
    adc_host_model_i.xfer(`CMD_STANDBY, 4, rx);
    adc_host_model_i.sel(1'b1);
    `CHK("dout released", 1'b1, oe_n)
    `CHK("standby cancel", 1'b0, stby)
    `CHK("read resumed", 1'b1, cont)
    adc_host_model_i.sel(1'b0);
    cmd(`CMD_RESET);
    `CHK("reset fir", 1'b1, fir)
    `CHK("reset rate", 3'h2, rate)
    settle(n);
  endtask

  task automatic t_pin;
    int   n;
    logic seen;
    fork
      lat(n);
      wr_cfg(8'h03);
    join
    `CHK("sinc latency", 1672, n)
    seen = 1'b0;
    @(posedge clk) rst_pin_n <= 1'b0;
    @(posedge clk) rst_pin_n <= 1'b1;
    repeat (8)
    begin
      cyc(1);
      seen = seen | int_rst;
    end
    `CHK("short pulse", 1'b0, seen)
    @(posedge clk) rst_pin_n <= 1'b0;
    cyc(20);
    `CHK("held reset", 1'b1, int_rst)
    `CHK("pin defaults", 3'h2, rate)
    @(posedge clk) rst_pin_n <= 1'b1;
    settle(n);
    `CHK("pin release", 1'b1, n > 0 && n < 300)
  endtask

  task automatic t_pd;
    int n;
    wr_cfg(8'h03);
    @(posedge clk) power_down_n <= 1'b0;
    cyc(10);
    `CHK("powered down", 1'b1, pdn)
    `CHK("pd ready", 1'b1, ready_n)
    @(posedge clk) power_down_n <= 1'b1;
    settle(n);
    `CHK("pd fir", 1'b1, fir)
    `CHK("pd rate", 3'h2, rate)
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic test_done;
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    rst         = 1'b1;
    rst_pin_n   = 1'b1;
    power_down_n = 1'b1;
    sup         = 2'h0;
    fails       = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_por;
    adc_host_model_i.sel(1'b0);
    t_fir;
    t_wake;
    t_tmo;
    t_cfg;
    t_pin;
    t_pd;
    test_done;
  end

  // Three long waits of about 17k cycles each; generous margin
  initial
  begin
    #(90000 * 50);
    fails++;
    test_done;
  end
endmodule
`default_nettype wire
